// *** clb_pkg.sv ***
package clb_pkg;
  typedef enum logic [2:0] {
    KIND_READ, KIND_FETCH, KIND_WRITE, KIND_INT_ACK_N, KIND_HALT
  } clb_kind_t;
  typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_T3, ST_WAIT, ST_T4} clb_state_t;
  // Cycle status, active low
  localparam logic [2:0] STAT_INT_ACK_N = 3'h0;
  localparam logic [2:0] STAT_IO_RD = 3'h1;
  localparam logic [2:0] STAT_IO_WR = 3'h2;
  localparam logic [2:0] STAT_HALT = 3'h3;
  localparam logic [2:0] STAT_FETCH = 3'h4;
  localparam logic [2:0] STAT_MEM_RD = 3'h5;
  localparam logic [2:0] STAT_MEM_WR = 3'h6;
  localparam logic [2:0] STAT_PASSIVE = 3'h7;
  localparam logic [15:0] AD_RST = 16'h0000;
  localparam logic [3:0] ADDR_HI_RST = 4'h0;
  localparam logic PH_LAST = 1'b1;

  function automatic logic [2:0] status_code(input clb_kind_t k, input logic io);
    case (k)
      KIND_READ: return io ? STAT_IO_RD : STAT_MEM_RD;
      KIND_FETCH: return STAT_FETCH;
      KIND_WRITE: return io ? STAT_IO_WR : STAT_MEM_WR;
      KIND_INT_ACK_N: return STAT_INT_ACK_N;
      KIND_HALT: return STAT_HALT;
      default: return STAT_PASSIVE;
    endcase
  endfunction

  // Odd bytes on upper lanes
  function automatic logic [15:0] lane_in(input logic [15:0] d, input logic byte_op,
                                          input logic a0);
    if (!byte_op) return d;
    return a0 ? {8'h00, d[15:8]} : {8'h00, d[7:0]};
  endfunction

  function automatic logic [15:0] lane_out(input logic [15:0] d, input logic byte_op,
                                           input logic a0);
    return (byte_op && a0) ? {d[7:0], 8'h00} : d;
  endfunction
endpackage

// *** clb_bus_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface clb_bus_if (
  input wire logic clk_i,
  input wire logic rst_i
);
  logic ale;
  logic [15:0] dev_ad;
  logic dev_ad_oe;
  logic [3:0] addr_hi;
  logic high_byte_enable_n;
  logic mem_io;
  logic rd_n;
  logic wr_n;
  logic int_ack_n;
  logic xcvr_direction;
  logic xcvr_enable_n;
  logic cycle_status_2;
  logic cycle_status_1;
  logic cycle_status_0;
  logic lock_n;
  logic hold_ack;
  logic arbiter_bus_select;
  logic [15:0] far_ad;
  logic far_ad_oe;
  logic ready;
  logic hold_req;
  logic [15:0] addr_data_bus;
  logic [15:0] held;

  // Undriven bus keeps its last level
  assign addr_data_bus = dev_ad_oe ? dev_ad : (far_ad_oe ? far_ad : held);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) held <= clb_pkg::AD_RST;
    else held <= addr_data_bus;
  end

  modport dev (
    output ale, dev_ad, dev_ad_oe, addr_hi, high_byte_enable_n, mem_io, rd_n, wr_n,
    output int_ack_n, xcvr_direction, xcvr_enable_n, cycle_status_2, cycle_status_1,
    output cycle_status_0, lock_n, hold_ack, arbiter_bus_select,
    input addr_data_bus, ready, hold_req
  );
  modport far (
    input ale, addr_hi, high_byte_enable_n, mem_io, rd_n, wr_n, int_ack_n,
    input cycle_status_2, cycle_status_1, cycle_status_0, lock_n, hold_ack,
    input arbiter_bus_select, addr_data_bus,
    output far_ad, far_ad_oe, ready, hold_req
  );
endinterface
`default_nettype wire

// *** clb_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module clb_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr;
  logic [AW:0] count;
  logic push, pop;

  assign in_ready_o = count != (AW+1)'(DEPTH);
  assign out_valid_o = count != '0;
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) mem[wr_ptr] <= in_data_i;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// *** clb_device_end.sv ***
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RL1] Address latch strobe pulses in T1
// [RL2] Byte enable and address bit pick lanes
// [RL3] Memory/IO select steady T1 through T4
// [RL4] Read releases address bus at T2
// [RL5] Read strobe later in T2 than write
// [RL6] Addressed device drives data, then ready
// [RL7] Drive transceiver direction and enable
// [RL8] Write data from T2 until T4
// [RL9] Write strobe T2, T3 and waits
// [RL10] Even bytes low lanes, odd upper
// [RL11] Acknowledge cycle is read without address
// [RL12] Two acknowledges, type byte on second
// [RL13] Type byte times four gives pointer
// [RL14] Strap low: maximum mode, no strobes
// [RL15] Status outputs encode cycle type
// [RL16] Controller offers normal and advanced writes
// [RL17] Maximum mode transceiver from controller
// [RL18] Acknowledge drives arbiter bus select
// [RL19] Strap high: minimum mode, own strobes
// [RL20] Lock across acknowledges, hold deferred
// [RL21] Ready sampled end of T3, waits
module clb_device_end #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  clb_bus_if.dev bus,
  input wire logic mode_strap_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire clb_pkg::clb_kind_t req_kind_i,
  input wire logic req_io_i,
  input wire logic req_byte_i,
  input wire logic [19:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  output logic rsp_valid_o,
  input wire logic rsp_ready_i,
  output logic [15:0] rsp_data_o,
  output logic rsp_vector_o
);
  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  clb_pkg::clb_state_t state, next_state;
  clb_pkg::clb_kind_t kind, next_kind;
  logic ph, next_ph, io, byte_op, second, next_io, next_byte, next_second;
  logic [19:0] addr, next_addr;
  logic [15:0] wdata, next_wdata, cap_word;
  logic mode_max, strap_done, take, end_t3, cap, fifo_in_ready;

  assign take = (state == clb_pkg::ST_IDLE) && req_valid_i && req_ready_o;
  assign end_t3 = (state == clb_pkg::ST_T3 || state == clb_pkg::ST_WAIT) && ph;

  always_comb begin
    next_state = state;
    case (state)
      clb_pkg::ST_IDLE: if (take) next_state = clb_pkg::ST_T1;
      clb_pkg::ST_T1: begin
        if (ph) next_state = (kind == clb_pkg::KIND_HALT) ? clb_pkg::ST_IDLE : clb_pkg::ST_T2;
      end
      clb_pkg::ST_T2: if (ph) next_state = clb_pkg::ST_T3;
      clb_pkg::ST_T3, clb_pkg::ST_WAIT: begin
        if (ph) next_state = bus.ready ? clb_pkg::ST_T4 : clb_pkg::ST_WAIT; // RL21
      end
      clb_pkg::ST_T4: begin
        if (ph && kind == clb_pkg::KIND_INT_ACK_N && !second) next_state = clb_pkg::ST_T1; // RL12
        else if (ph) next_state = clb_pkg::ST_IDLE;
      end
      default: next_state = clb_pkg::ST_IDLE;
    endcase
  end

  // Two clocks per T-state so read lags write
  assign next_ph = (state == clb_pkg::ST_IDLE || next_state == clb_pkg::ST_IDLE) ? 1'b0 : ~ph;
  assign next_kind = take ? req_kind_i : kind;
  assign next_io = take ? req_io_i : io;
  assign next_byte = take ? req_byte_i : byte_op;
  assign next_addr = take ? req_addr_i : addr;
  assign next_wdata = take ? req_wdata_i : wdata;
  assign next_second = take ? 1'b0 :
    ((state == clb_pkg::ST_T4 && ph && kind == clb_pkg::KIND_INT_ACK_N) ? 1'b1 : second);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= clb_pkg::ST_IDLE;
      ph <= 1'b0;
      kind <= clb_pkg::KIND_READ;
      io <= 1'b0;
      byte_op <= 1'b0;
      second <= 1'b0;
      addr <= '0;
      wdata <= '0;
    end else begin
      state <= next_state;
      ph <= next_ph;
      kind <= next_kind;
      io <= next_io;
      byte_op <= next_byte;
      second <= next_second;
      addr <= next_addr;
      wdata <= next_wdata;
    end
  end

  // Strap taken once after reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_max <= 1'b0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      mode_max <= !mode_strap_i; // RL14 RL19
      strap_done <= 1'b1;
    end
  end

  // ----------------------------------------
  // Pin decode, registered
  // ----------------------------------------
  logic in_t1, in_t2, in_t3w, in_t4, active, min_mode;
  logic is_rd, is_wr, is_ia, rd_win, wr_win;
  logic next_ale, next_ad_oe, next_bhe_n, next_mem_io, next_rd_n, next_wr_n;
  logic next_int_ack_n_n, next_dir, next_en_n, next_lock_n, next_sel, next_hold_ack;
  logic next_req_ready;
  logic [15:0] next_ad;
  logic [2:0] next_status;

  assign in_t1 = next_state == clb_pkg::ST_T1;
  assign in_t2 = next_state == clb_pkg::ST_T2;
  assign in_t3w = next_state == clb_pkg::ST_T3 || next_state == clb_pkg::ST_WAIT;
  assign in_t4 = next_state == clb_pkg::ST_T4;
  assign active = next_state != clb_pkg::ST_IDLE;
  assign min_mode = !mode_max;
  assign is_rd = next_kind == clb_pkg::KIND_READ || next_kind == clb_pkg::KIND_FETCH;
  assign is_wr = next_kind == clb_pkg::KIND_WRITE;
  assign is_ia = next_kind == clb_pkg::KIND_INT_ACK_N;
  assign rd_win = (in_t2 && next_ph == clb_pkg::PH_LAST) || in_t3w; // RL5
  assign wr_win = in_t2 || in_t3w; // RL9

  assign next_ale = in_t1 && next_ph != clb_pkg::PH_LAST; // RL1
  // Acknowledges leave address to keepers
  assign next_ad_oe = (in_t1 && (is_rd || is_wr)) || (is_wr && (wr_win || in_t4)); // RL4 RL8 RL11
  assign next_ad = in_t1 ? next_addr[15:0] :
    clb_pkg::lane_out(next_wdata, next_byte, next_addr[0]); // RL10
  assign next_bhe_n = next_byte && !next_addr[0]; // RL2
  assign next_mem_io = active ? (!next_io && !is_ia) : bus.mem_io; // RL3
  assign next_rd_n = !(min_mode && is_rd && rd_win); // RL14 RL19
  assign next_wr_n = !(min_mode && is_wr && wr_win); // RL9
  assign next_int_ack_n_n = !(min_mode && is_ia && rd_win); // RL11
  assign next_dir = !(min_mode && active && !is_wr); // RL7
  assign next_en_n = !(min_mode && ((is_wr && (wr_win || in_t4)) || (!is_wr && rd_win))); // RL7
  assign next_status = (mode_max && (in_t1 || in_t2 || in_t3w)) ?
    clb_pkg::status_code(next_kind, next_io) : clb_pkg::STAT_PASSIVE; // RL15
  assign next_lock_n = !(mode_max && is_ia &&
    ((!next_second && (in_t2 || in_t3w || in_t4)) || (next_second && in_t1))); // RL20
  assign next_sel = is_ia && rd_win; // RL18
  // Hold only from idle, never between acknowledges
  assign next_hold_ack = bus.hold_req &&
    (bus.hold_ack || (state == clb_pkg::ST_IDLE && !active)); // RL20
  assign next_req_ready = !active && strap_done && fifo_in_ready && !bus.hold_req &&
    !next_hold_ack;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus.ale <= 1'b0;
      bus.dev_ad <= clb_pkg::AD_RST;
      bus.dev_ad_oe <= 1'b0;
      bus.addr_hi <= clb_pkg::ADDR_HI_RST;
      bus.high_byte_enable_n <= 1'b1;
      bus.mem_io <= 1'b0;
      bus.rd_n <= 1'b1;
      bus.wr_n <= 1'b1;
      bus.int_ack_n <= 1'b1;
      bus.xcvr_direction <= 1'b1;
      bus.xcvr_enable_n <= 1'b1;
      {bus.cycle_status_2, bus.cycle_status_1, bus.cycle_status_0} <= clb_pkg::STAT_PASSIVE;
      bus.lock_n <= 1'b1;
      bus.arbiter_bus_select <= 1'b0;
      bus.hold_ack <= 1'b0;
      req_ready_o <= 1'b0;
    end else begin
      bus.ale <= next_ale;
      bus.dev_ad <= next_ad;
      bus.dev_ad_oe <= next_ad_oe;
      bus.addr_hi <= next_addr[19:16];
      bus.high_byte_enable_n <= next_bhe_n;
      bus.mem_io <= next_mem_io;
      bus.rd_n <= next_rd_n;
      bus.wr_n <= next_wr_n;
      bus.int_ack_n <= next_int_ack_n_n;
      bus.xcvr_direction <= next_dir;
      bus.xcvr_enable_n <= next_en_n;
      {bus.cycle_status_2, bus.cycle_status_1, bus.cycle_status_0} <= next_status;
      bus.lock_n <= next_lock_n;
      bus.arbiter_bus_select <= next_sel;
      bus.hold_ack <= next_hold_ack;
      req_ready_o <= next_req_ready;
    end
  end

  // ----------------------------------------
  // Read data and vector capture
  // ----------------------------------------
  // Room checked at take, push never stalls
  assign cap = end_t3 && bus.ready && (kind == clb_pkg::KIND_READ ||
    kind == clb_pkg::KIND_FETCH || (kind == clb_pkg::KIND_INT_ACK_N && second)); // RL12 RL21
  assign cap_word = (kind == clb_pkg::KIND_INT_ACK_N) ?
    {6'h00, bus.addr_data_bus[7:0], 2'h0} : // RL13
    clb_pkg::lane_in(bus.addr_data_bus, byte_op, addr[0]); // RL10

  clb_fifo #(
    .WIDTH(17),
    .DEPTH(FIFO_DEPTH)
  ) u_rsp_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(cap),
    .in_ready_o(fifo_in_ready),
    .in_data_i({kind == clb_pkg::KIND_INT_ACK_N, cap_word}),
    .out_valid_o(rsp_valid_o),
    .out_ready_i(rsp_ready_i),
    .out_data_o({rsp_vector_o, rsp_data_o})
  );
endmodule
`default_nettype wire

// *** clb_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module clb_far_end #(
  parameter int MEM_WORDS = 256,
  parameter int WAIT_STATES = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  clb_bus_if.far bus,
  input wire logic mode_strap_i,
  input wire logic [7:0] irq_type_i,
  input wire logic hold_req_i,
  output logic hold_ack_o,
  output logic wr_pulse_o,
  output logic [19:0] wr_addr_o,
  output logic [15:0] wr_data_o,
  output logic wr_norm_n_o,
  output logic wr_adv_n_o,
  output logic xcvr_direction_o,
  output logic xcvr_enable_n_o
);
  localparam int MAW = $clog2(MEM_WORDS);
  if (MEM_WORDS < 2 || (1 << MAW) != MEM_WORDS) $error("memory size must be a power of two");
  if (WAIT_STATES < 0 || WAIT_STATES > 15) $error("wait states out of range");

  logic [15:0] mem [MEM_WORDS];
  logic [19:0] lat_addr;
  logic [2:0] lat_stat, stat_now;
  logic [3:0] since, wcnt;
  logic lat_bhe_n, cyc, ale_q, wr_q, ia_odd, ia_q, ia_end, mode_max;
  logic rd_on, wr_on, ia_on, adv_on, norm_on;

  assign mode_max = !mode_strap_i;
  assign stat_now = {bus.cycle_status_2, bus.cycle_status_1, bus.cycle_status_0};
  // Maximum mode: commands from latched status
  assign adv_on = cyc && stat_now != clb_pkg::STAT_PASSIVE;
  assign norm_on = adv_on && since != 4'h0;
  assign rd_on = mode_max ? adv_on && (lat_stat == clb_pkg::STAT_MEM_RD ||
    lat_stat == clb_pkg::STAT_IO_RD || lat_stat == clb_pkg::STAT_FETCH) : !bus.rd_n;
  assign wr_on = mode_max ? norm_on && (lat_stat == clb_pkg::STAT_MEM_WR ||
    lat_stat == clb_pkg::STAT_IO_WR) : !bus.wr_n;
  assign ia_on = mode_max ? adv_on && lat_stat == clb_pkg::STAT_INT_ACK_N : !bus.int_ack_n;
  assign ia_end = ia_q && !ia_on;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ale_q <= 1'b0;
      cyc <= 1'b0;
      since <= '0;
      lat_addr <= '0;
      lat_bhe_n <= 1'b1;
      lat_stat <= clb_pkg::STAT_PASSIVE;
      wr_q <= 1'b0;
      ia_q <= 1'b0;
      ia_odd <= 1'b0;
      wcnt <= '0;
    end else begin
      ale_q <= bus.ale;
      wr_q <= wr_on;
      ia_q <= ia_on;
      if (ia_end) ia_odd <= !ia_odd;
      wcnt <= (rd_on || ia_on) ? wcnt + 4'h1 : 4'h0;
      if (ale_q && !bus.ale) begin
        cyc <= 1'b1;
        since <= '0;
        lat_addr <= {bus.addr_hi, bus.addr_data_bus};
        lat_bhe_n <= bus.high_byte_enable_n;
        lat_stat <= stat_now;
      end else if (cyc) begin
        since <= since + 4'h1;
        if (stat_now == clb_pkg::STAT_PASSIVE && since != 4'h0) cyc <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Responder pins
  // ----------------------------------------
  // Release lags a clock, absorbed by T4
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus.far_ad <= clb_pkg::AD_RST;
      bus.far_ad_oe <= 1'b0;
      bus.ready <= 1'b1;
      bus.hold_req <= 1'b0;
      hold_ack_o <= 1'b0;
      wr_norm_n_o <= 1'b1;
      wr_adv_n_o <= 1'b1;
      xcvr_direction_o <= 1'b1;
      xcvr_enable_n_o <= 1'b1;
    end else begin
      bus.far_ad_oe <= rd_on || (ia_on && ia_odd); // RL6 RL12
      bus.far_ad <= ia_on ? {8'h00, irq_type_i} : mem[lat_addr[MAW:1]];
      bus.ready <= !((rd_on || ia_on) && wcnt < 4'(WAIT_STATES)); // RL6
      bus.hold_req <= hold_req_i;
      hold_ack_o <= bus.hold_ack;
      wr_norm_n_o <= !(mode_max && wr_on); // RL16
      wr_adv_n_o <= !(mode_max && adv_on && (lat_stat == clb_pkg::STAT_MEM_WR ||
        lat_stat == clb_pkg::STAT_IO_WR)); // RL16
      xcvr_direction_o <= !(mode_max && cyc && (rd_on || ia_on)); // RL17
      xcvr_enable_n_o <= !(mode_max && (rd_on || ia_on || wr_on)); // RL17
    end
  end

  // Write lands as the command ends
  always_ff @(posedge clk_i) begin
    if (wr_q && !wr_on) begin
      if (!lat_addr[0]) mem[lat_addr[MAW:1]][7:0] <= bus.addr_data_bus[7:0];
      if (!lat_bhe_n) mem[lat_addr[MAW:1]][15:8] <= bus.addr_data_bus[15:8];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pulse_o <= 1'b0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
    end else begin
      wr_pulse_o <= wr_q && !wr_on;
      if (wr_q && !wr_on) begin
        wr_addr_o <= lat_addr;
        wr_data_o <= bus.addr_data_bus;
      end
    end
  end
endmodule
`default_nettype wire

// *** clb_bus_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module clb_bus_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mode_strap_i,
  input wire logic ale,
  input wire logic [15:0] dev_ad,
  input wire logic dev_ad_oe,
  input wire logic high_byte_enable_n,
  input wire logic mem_io,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic int_ack_n,
  input wire logic xcvr_direction,
  input wire logic xcvr_enable_n,
  input wire logic cycle_status_2,
  input wire logic cycle_status_1,
  input wire logic cycle_status_0,
  input wire logic lock_n,
  input wire logic hold_ack,
  input wire logic arbiter_bus_select,
  input wire logic ready,
  input wire logic [15:0] addr_data_bus
);
  logic lat_bhe_n, lat_a0;
  logic [2:0] status;
  assign status = {cycle_status_2, cycle_status_1, cycle_status_0};

  // ------------------------------
  // Byte select as an address latch holds it
  // ------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lat_bhe_n <= 1'b0;
      lat_a0 <= 1'b0;
    end else if (ale) begin
      lat_bhe_n <= high_byte_enable_n;
      lat_a0 <= addr_data_bus[0];
    end
  end

  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_addr_phase;
    rd_n && wr_n && int_ack_n ##1 !ale && rd_n && wr_n && int_ack_n;
  endsequence
  sequence s_wr_data_hold;
    dev_ad_oe && $stable(dev_ad) ##1 dev_ad_oe && $stable(dev_ad);
  endsequence

  property p_ale_pulse;
    $rose(ale) |-> s_addr_phase;
  endproperty
  a_ale_pulse: assert property (p_ale_pulse) else $error("ale overlaps strobe");
  property p_rd_start;
    $fell(rd_n) |-> $past(ale, 3) && $past(!dev_ad_oe) && !dev_ad_oe && !xcvr_enable_n
      && !xcvr_direction;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("bad read start");
  property p_wr_start;
    $fell(wr_n) |-> $past(ale, 2) && dev_ad_oe && xcvr_direction && !xcvr_enable_n ##1 (!wr_n)[*3];
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("bad write start");
  property p_wr_hold;
    $rose(wr_n) |-> s_wr_data_hold;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write data dropped early");
  property p_wait;
    (!rd_n || !wr_n) && !ready |=> !rd_n || !wr_n;
  endproperty
  a_wait: assert property (p_wait) else $error("strobe ended early");
  property p_rd_bound;
    $fell(rd_n) |-> ##[3:60] rd_n;
  endproperty
  a_rd_bound: assert property (p_rd_bound) else $error("bad read length");
  property p_mem_io;
    (!rd_n || !wr_n || !int_ack_n) |-> $stable(mem_io);
  endproperty
  a_mem_io: assert property (p_mem_io) else $error("mem_io moved");
  property p_byte_sel;
    !wr_n |-> !(lat_bhe_n && lat_a0);
  endproperty
  a_byte_sel: assert property (p_byte_sel) else $error("no byte selected");
  property p_ack;
    !int_ack_n |-> arbiter_bus_select && !dev_ad_oe;
  endproperty
  a_ack: assert property (p_ack) else $error("bad acknowledge");
  property p_max_quiet;
    !mode_strap_i |-> rd_n && wr_n && int_ack_n;
  endproperty
  a_max_quiet: assert property (p_max_quiet) else $error("strobe in maximum mode");
  property p_status;
    $rose(ale) && !mode_strap_i |-> status != clb_pkg::STAT_PASSIVE ##1 $stable(status);
  endproperty
  a_status: assert property (p_status) else $error("cycle status missing");
  property p_lock_span;
    $fell(lock_n) |-> (!lock_n)[*8];
  endproperty
  a_lock_span: assert property (p_lock_span) else $error("lock too short");
  property p_lock_hold;
    !lock_n |-> !hold_ack;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("hold granted under lock");
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic strap = 1'b1;
  logic req_valid = 1'b0;
  clb_pkg::clb_kind_t req_kind = clb_pkg::KIND_READ;
  logic req_io = 1'b0;
  logic req_byte = 1'b0;
  logic [19:0] req_addr = 20'h0;
  logic [15:0] req_wdata = 16'h0;
  logic rsp_ready = 1'b0;
  logic [7:0] irq_type = 8'h00;
  logic hold_req = 1'b0;
  logic req_ready, rsp_valid, rsp_vector, wr_pulse, wr_norm_n, wr_adv_n, xdir, xen_n, hold_ack;
  logic [15:0] rsp_data, wr_data, d;
  logic [19:0] wr_addr, a;
  logic io, b2;
  logic [15:0] mem [logic [7:0]];
  logic [16:0] exp_q [$];
  int miscompares = 0, check_count = 0, i;

  always #12.5 clk_i = ~clk_i;

  clb_bus_if u_clb_bus_if (.clk_i(clk_i), .rst_i(rst_i));
  clb_device_end u_clb_device_end (
    .clk_i(clk_i), .rst_i(rst_i), .bus(u_clb_bus_if.dev), .mode_strap_i(strap),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_kind_i(req_kind), .req_io_i(req_io),
    .req_byte_i(req_byte), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
    .rsp_valid_o(rsp_valid), .rsp_ready_i(rsp_ready), .rsp_data_o(rsp_data),
    .rsp_vector_o(rsp_vector)
  );
  clb_far_end u_clb_far_end (
    .clk_i(clk_i), .rst_i(rst_i), .bus(u_clb_bus_if.far), .mode_strap_i(strap),
    .irq_type_i(irq_type), .hold_req_i(hold_req), .hold_ack_o(hold_ack), .wr_pulse_o(wr_pulse),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_norm_n_o(wr_norm_n), .wr_adv_n_o(wr_adv_n),
    .xcvr_direction_o(xdir), .xcvr_enable_n_o(xen_n)
  );
  clb_bus_properties u_clb_bus_properties (
    .clk_i(clk_i), .rst_i(rst_i), .mode_strap_i(strap), .ale(u_clb_bus_if.ale),
    .dev_ad(u_clb_bus_if.dev_ad), .dev_ad_oe(u_clb_bus_if.dev_ad_oe),
    .high_byte_enable_n(u_clb_bus_if.high_byte_enable_n), .mem_io(u_clb_bus_if.mem_io),
    .rd_n(u_clb_bus_if.rd_n), .wr_n(u_clb_bus_if.wr_n), .int_ack_n(u_clb_bus_if.int_ack_n),
    .xcvr_direction(u_clb_bus_if.xcvr_direction), .xcvr_enable_n(u_clb_bus_if.xcvr_enable_n),
    .cycle_status_2(u_clb_bus_if.cycle_status_2), .cycle_status_1(u_clb_bus_if.cycle_status_1),
    .cycle_status_0(u_clb_bus_if.cycle_status_0), .lock_n(u_clb_bus_if.lock_n),
    .hold_ack(u_clb_bus_if.hold_ack), .arbiter_bus_select(u_clb_bus_if.arbiter_bus_select),
    .ready(u_clb_bus_if.ready), .addr_data_bus(u_clb_bus_if.addr_data_bus)
  );

  // ------------------------------
  // Checking and stimulus tasks
  // ------------------------------
  task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  function automatic logic [15:0] rd_exp(input logic [15:0] w, input logic b, input logic a0);
    return !b ? w : (a0 ? {8'h00, w[15:8]} : {8'h00, w[7:0]});
  endfunction

  task automatic do_reset(input logic s);
    rst_i = 1'b1;
    strap = s;
    repeat (3) @(posedge clk_i);
    #1 rst_i = 1'b0;
  endtask

  task automatic issue(input clb_pkg::clb_kind_t k, input logic io_sel, input logic b,
                       input logic [19:0] ad, input logic [15:0] wd);
    int n;
    logic [15:0] m, lane;
    m = b ? (ad[0] ? 16'hff00 : 16'h00ff) : 16'hffff;
    lane = (b && ad[0]) ? {wd[7:0], 8'h00} : wd;
    for (n = 0; n < 200 && req_ready !== 1'b1; n++) cyc(1);
    check("req_ready", 1, req_ready);
    req_valid = 1'b1;
    req_kind = k;
    req_io = io_sel;
    req_byte = b;
    req_addr = ad;
    req_wdata = wd;
    cyc(1);
    req_valid = 1'b0;
    if (k == clb_pkg::KIND_INT_ACK_N) exp_q.push_back({1'b1, 6'h00, irq_type, 2'b00});
    if (k == clb_pkg::KIND_READ || k == clb_pkg::KIND_FETCH)
      exp_q.push_back({1'b0, rd_exp(mem[ad[8:1]], b, ad[0])});
    if (k == clb_pkg::KIND_INT_ACK_N || k == clb_pkg::KIND_HALT) return;
    for (n = 0; n < 20 && u_clb_bus_if.ale !== 1'b1; n++) cyc(1);
    check("addr_bus", ad[15:0], u_clb_bus_if.addr_data_bus);
    check("addr_hi", ad[19:16], u_clb_bus_if.addr_hi);
    check("byte_enable_n", b && !ad[0], u_clb_bus_if.high_byte_enable_n);
    check("mem_io", !io_sel, u_clb_bus_if.mem_io);
    if (k != clb_pkg::KIND_WRITE) return;
    mem[ad[8:1]] = (mem[ad[8:1]] & ~m) | (lane & m);
    if (!strap) begin
      for (n = 0; n < 20 && wr_adv_n !== 1'b0; n++) cyc(1);
      check("wr_norm_n_early", 1, wr_norm_n);
      cyc(1);
      check("wr_norm_n", 0, wr_norm_n);
      check("data_at_norm", lane & m, u_clb_bus_if.addr_data_bus & m);
      check("xcvr_dir_en", 2'b10, {xdir, xen_n});
    end
    for (n = 0; n < 40 && wr_pulse !== 1'b1; n++) cyc(1);
    check("wr_addr", ad, wr_addr);
    check("wr_data", lane & m, wr_data & m);
  endtask

  // Seen off the edge; the next edge pops it
  task automatic drain(input int cnt);
    int n;
    logic [16:0] e;
    rsp_ready = 1'b1;
    for (n = 0; n < 400 && cnt > 0; n++) begin
      if (rsp_valid === 1'b1) begin
        e = exp_q.pop_front();
        check("rsp_vector", e[16], rsp_vector);
        check("rsp_data", e[15:0], rsp_data);
        cnt--;
      end
      cyc(1);
    end
    rsp_ready = 1'b0;
    check("rsp_missing", 0, cnt);
  endtask

  // ------------------------------
  // Main sequence and watchdog
  // ------------------------------
  initial begin
    void'($urandom(32'ha321047f));
    do_reset(1'b1);
    for (i = 0; i < 14; i++) begin
      io = i > 1 ? 1'($urandom()) : 1'b0;
      a = i == 0 ? 20'hffffe : (i == 1 ? 20'h00000 : 20'($urandom()) & 20'hffffe);
      if (io) a[19:16] = 4'h0;
      d = 16'($urandom());
      b2 = 1'($urandom());
      issue(clb_pkg::KIND_WRITE, io, 1'b0, a, d);
      issue(clb_pkg::KIND_WRITE, io, 1'b1, a | 20'(b2), ~d);
      issue(i[0] && !io ? clb_pkg::KIND_FETCH : clb_pkg::KIND_READ, io, 1'b0, a, 16'h0);
      drain(1);
      issue(clb_pkg::KIND_READ, io, 1'b1, a | 20'(!b2), 16'h0);
      drain(1);
    end
    for (i = 0; i < 3; i++) begin
      irq_type = i == 0 ? 8'hff : 8'($urandom());
      issue(clb_pkg::KIND_INT_ACK_N, 1'b0, 1'b0, 20'h0, 16'h0);
      drain(1);
    end
    for (i = 0; i < 4; i++) issue(clb_pkg::KIND_READ, 1'b0, 1'b0, 20'h0, 16'h0);
    cyc(30);
    check("req_ready_full", 0, req_ready);
    drain(4);
    issue(clb_pkg::KIND_HALT, 1'b0, 1'b0, 20'h0, 16'h0);
    cyc(20);
    check("halt_no_rsp", 0, rsp_valid);
    do_reset(1'b0);
    for (i = 0; i < 4; i++) begin
      a = 20'($urandom()) & 20'hffffe;
      d = 16'($urandom());
      issue(clb_pkg::KIND_WRITE, 1'b0, 1'b0, a, d);
      issue(clb_pkg::KIND_READ, 1'b0, 1'b0, a, 16'h0);
      drain(1);
    end
    irq_type = 8'h5a;
    issue(clb_pkg::KIND_INT_ACK_N, 1'b0, 1'b0, 20'h0, 16'h0);
    hold_req = 1'b1;
    drain(1);
    for (i = 0; i < 50 && hold_ack !== 1'b1; i++) cyc(1);
    check("hold_granted", 1, hold_ack);
    hold_req = 1'b0;
    for (i = 0; i < 50 && hold_ack !== 1'b0; i++) cyc(1);
    issue(clb_pkg::KIND_HALT, 1'b0, 1'b0, 20'h0, 16'h0);
    cyc(10);
    wrap_up();
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    check("watchdog", 0, 1);
    wrap_up();
  end
endmodule
`default_nettype wire
